// >>> verilog/rtc_timekeeper.sv
/*
  RTC timekeeping core: divider chain, calendar update, snapshot copy,
  alarm, periodic/update flags and host lockout, behind an Avalon-MM slave.
  Assumes osc_tick is a one-cycle pulse per 32.768 kHz period and the
  supply comparator results arrive synchronous to mclk.
*/
// Added by the designer: the register offsets and the Avalon-MM slave port.
// Notes on behaviour
// - counters use BCD or binary (CONTROL_REG_B bit 2) and 12/24 hour (CONTROL_REG_B bit 1).
// - February gets 29 days every fourth year automatically.
// - internal chain keeps advancing each second while snapshot bit is set.
// - setting snapshot copies time to user copies; host time access uses copies.
// - with snapshot set, host writes change only the user copies.
// - clearing snapshot loads copies into counters between two updates.
// - each update sets update-ended flag; interrupt if its enable is set.
// - time stays unchanged 999 ms after an update before the next.
// - update-in-progress rises 244 us before each update.
// - periodic flag fires half a period plus 244 us before an update.
// - after each update compare five fields to alarm; match sets flag, wakes.
// - alarm match drives interrupt only if alarm enable was set.
// - alarm field with top bits 11 always matches.
// - host inputs blocked while standby supply is below its threshold.
// - after standby appears, lock stays 62 to 125 ms unless fast release.
// - divider code 010 at standby detect releases lockout at once.
// - low battery and bus reset low: release at once and init 00h-0Dh.
// - valid-time flag reading 0 releases lockout at once.
// - divider code 000 stops oscillator once standby power is gone.
// - inactive oscillator suspends timekeeping, periodic and alarm.
// - 15-stage divider gives 1 Hz; first update 500 ms after activation.
// - reading status C clears all flags and drops the interrupt.
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeper
  import rtc_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LOCK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // avalon-mm slave, word addressed
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // timebase and supply comparators
  input wire logic osc_tick,
  input wire logic standby_on_threshold,
  input wire logic standby_off_threshold,
  input wire logic battery_detect_level,
  input wire logic battery_min_level,
  input wire logic bus_reset_in_n,
  // status outputs
  output logic irq,
  output logic wakeup_controller_alarm,
  output logic input_locked,
  output logic osc_active
);

  localparam int CW = $clog2(LOCK_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////
  // format helpers

  function automatic logic [7:0] to_bin(input logic [7:0] v,
                                        input logic bcd);
    to_bin = bcd ? ({4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]}) : v;
  endfunction : to_bin

  function automatic logic [7:0] to_fmt(input logic [7:0] b,
                                        input logic bcd);
    logic [7:0] t;
    logic [7:0] u;
    t = b / 8'h0a;
    u = b % 8'h0a;
    to_fmt = bcd ? {t[3:0], u[3:0]} : b;
  endfunction : to_fmt

  // hours as 0..23 whatever the stored format
  function automatic logic [7:0] hr_get(input logic [7:0] raw,
                                        input logic bcd,
                                        input logic h24);
    logic [7:0] h;
    h = to_bin({1'b0, raw[6:0]}, bcd);
    if (h24) begin
      hr_get = to_bin(raw, bcd);
    end else if (h == HALF_DAY) begin
      hr_get = raw[7] ? HALF_DAY : 8'h00;
    end else begin
      hr_get = raw[7] ? h + HALF_DAY : h;
    end
  endfunction : hr_get

  function automatic logic [7:0] hr_put(input logic [7:0] h,
                                        input logic bcd,
                                        input logic h24);
    logic [7:0] r;
    logic [7:0] f;
    r = (h >= HALF_DAY) ? h - HALF_DAY : h;
    if (r == 8'h00) begin
      r = HALF_DAY;
    end
    f = to_fmt(r, bcd);
    hr_put = h24 ? to_fmt(h, bcd) : {h >= HALF_DAY, f[6:0]};
  endfunction : hr_put

  function automatic logic [7:0] month_len(input logic [7:0] mo,
                                           input logic [7:0] y);
    if (mo == T_FEB) begin
      month_len = (y[1:0] == 2'h0) ? FEB_LEAP : FEB_NORM;
    end else if (SHORT_MONTHS[mo[3:0]]) begin
      month_len = SHORT_MON;
    end else begin
      month_len = LONG_MON;
    end
  endfunction : month_len

  // one-second advance of the whole calendar
  function automatic rtc_time_s tick(input rtc_time_s t,
                                     input logic bcd,
                                     input logic h24);
    logic [7:0] s;
    logic [7:0] m;
    logic [7:0] h;
    logic [7:0] w;
    logic [7:0] d;
    logic [7:0] mo;
    logic [7:0] y;
    s = to_bin(t.sec, bcd);
    m = to_bin(t.min, bcd);
    h = hr_get(t.hour, bcd, h24);
    w = t.dow;
    d = to_bin(t.dom, bcd);
    mo = to_bin(t.mon, bcd);
    y = to_bin(t.year, bcd);
    if (s < T_SEC_LAST) begin
      s = s + 8'h01;
    end else begin
      s = 8'h00;
      if (m < T_MIN_LAST) begin
        m = m + 8'h01;
      end else begin
        m = 8'h00;
        if (h < T_HR_LAST) begin
          h = h + 8'h01;
        end else begin
          h = 8'h00;
          w = (w >= T_DOW_LAST) ? T_FIRST : w + 8'h01;
          if (d < month_len(mo, y)) begin
            d = d + 8'h01;
          end else begin
            d = T_FIRST;
            if (mo < T_MON_LAST) begin
              mo = mo + 8'h01;
            end else begin
              mo = T_FIRST;
              y = (y >= T_YR_LAST) ? 8'h00 : y + 8'h01;
            end
          end
        end
      end
    end
    tick.sec = to_fmt(s, bcd);
    tick.min = to_fmt(m, bcd);
    tick.hour = hr_put(h, bcd, h24);
    tick.dow = w;
    tick.dom = to_fmt(d, bcd);
    tick.mon = to_fmt(mo, bcd);
    tick.year = to_fmt(y, bcd);
  endfunction : tick

  function automatic logic [7:0] t_get(input rtc_time_s t,
                                       input logic [3:0] i);
    case (i)
      IDX_SEC: t_get = t.sec;
      IDX_MIN: t_get = t.min;
      IDX_HOUR: t_get = t.hour;
      IDX_DOW: t_get = t.dow;
      IDX_DOM: t_get = t.dom;
      IDX_MON: t_get = t.mon;
      IDX_YEAR: t_get = t.year;
      default: t_get = 8'h00;
    endcase
  endfunction : t_get

  function automatic rtc_time_s t_put(input rtc_time_s t,
                                      input logic [3:0] i,
                                      input logic [7:0] d);
    t_put = t;
    case (i)
      IDX_SEC: t_put.sec = d;
      IDX_MIN: t_put.min = d;
      IDX_HOUR: t_put.hour = d;
      IDX_DOW: t_put.dow = d;
      IDX_DOM: t_put.dom = d;
      IDX_MON: t_put.mon = d;
      IDX_YEAR: t_put.year = d;
      default: t_put = t;
    endcase
  endfunction : t_put

  function automatic logic al_hit(input logic [7:0] cur,
                                  input logic [7:0] al);
    al_hit = (al[7:6] == AL_DONT_CARE) || (al == cur);
  endfunction : al_hit

  //////////////////////////////////////////////////////////////////////////
  // state

  rtc_time_s tm;
  rtc_time_s ucp;
  rtc_alarm_s alm;
  logic [2:0] dv;
  logic [3:0] rs;
  logic [7:0] control_reg_b;
  logic uf;
  logic af;
  logic pf;
  logic uip;
  logic [DIV_W-1:0] div;
  logic pend_load;
  logic upd_d;
  logic valid_time_flag;
  logic sb_ok;
  logic ack;
  logic [CW-1:0] lk_cnt;
  rtc_lock_e lk;
  rtc_lock_e next_lk;
  rtc_time_s next_tm;
  rtc_time_s next_ucp;

  //////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle, then the answer

  wire req = avs_read | avs_write;
  wire locked = (lk != LK_OPEN);
  wire done = req & ack;
  wire [7:0] wd = avs_writedata[7:0];
  wire wr = avs_write & done & ~locked & avs_byteenable[0];
  wire rd = avs_read & done & ~locked;
  wire is_time = (t_get('1, avs_address) != 8'h00);
  wire snap_on = control_reg_b[CRB_SET];
  wire tm_wr = wr & is_time & ~snap_on;
  wire ucp_wr = wr & is_time & snap_on;
  wire crb_wr = wr & (avs_address == IDX_CRB);
  wire cra_wr = wr & (avs_address == IDX_CRA);
  wire snap_take = crb_wr & wd[CRB_SET] & ~snap_on;
  wire snap_drop = crb_wr & ~wd[CRB_SET] & snap_on;
  wire c_clr = rd & (avs_address == IDX_CRC);

  assign avs_waitrequest = req & ~ack;

  //////////////////////////////////////////////////////////////////////////
  // oscillator and divider chain

  wire bcd = ~control_reg_b[CRB_DM];
  wire h24 = control_reg_b[CRB_24H];
  // stopped only by code 000 or a dead battery, and only off standby
  assign osc_active = sb_ok | (battery_min_level & (dv != DV_STOP));
  wire chain_rst = (dv[2:1] == DV_RST_TOP);
  wire chain_run = osc_active & (dv == DV_NORMAL);
  wire tk = osc_tick & chain_run;
  wire [DIV_W-1:0] div_nx = div + 15'h0001;
  // the 1 Hz edge sits half way round the chain: 500 ms after a restart
  wire upd = tk & (div_nx == UPD_POINT);
  wire uip_rise = tk & (div_nx == UIP_START);

  // periodic rate: shift of the tap period in oscillator ticks
  wire [3:0] psh = (rs == 4'h1) ? PER_SHIFT_R1 :
                   (rs == 4'h2) ? PER_SHIFT_R2 : rs - 4'h1;
  wire [DIV_W-1:0] pmask = (15'h0001 << psh) - 15'h0001;
  wire [DIV_W-1:0] phalf = 15'h0001 << (psh - 4'h1);
  wire [DIV_W-1:0] ptgt = (15'h0000 - phalf - 15'(UIP_TICKS)) & pmask;
  wire pfire = tk & (rs != 4'h0) & ((div_nx & pmask) == ptgt);

  //////////////////////////////////////////////////////////////////////////
  // alarm compare and power lockout decode

  wire al_match = al_hit(tm.sec, alm.sec) & al_hit(tm.min, alm.min) &
                  al_hit(tm.hour, alm.hour) & al_hit(tm.dom, alm.dom) &
                  al_hit(tm.mon, alm.mon);
  wire al_set = upd_d & al_match;
  wire bat_dead_rst = ~battery_detect_level & ~bus_reset_in_n;
  wire fast_open = (dv == DV_NORMAL) | ~valid_time_flag | bat_dead_rst;
  wire init = (lk == LK_DOWN) & sb_ok & bat_dead_rst;
  wire load_now = pend_load & ~upd;
  wire irq_pending_flag = (pf & control_reg_b[CRB_PIE]) | (af & control_reg_b[CRB_AIE]) |
              (uf & control_reg_b[CRB_UIE]);

  assign irq = irq_pending_flag;
  assign input_locked = locked;

  always_comb begin
    next_tm = tm;
    if (upd) begin
      next_tm = tick(tm, bcd, h24);
    end else if (load_now) begin
      next_tm = ucp;
    end
    if (tm_wr) begin
      next_tm = t_put(next_tm, avs_address, wd);
    end
    if (init) begin
      next_tm = '0;
    end
  end

  always_comb begin
    next_ucp = snap_take ? tm : ucp;
    if (ucp_wr) begin
      next_ucp = t_put(next_ucp, avs_address, wd);
    end
    if (init) begin
      next_ucp = '0;
    end
  end

  always_comb begin
    next_lk = lk;
    case (lk)
      LK_DOWN: begin
        if (sb_ok) begin
          next_lk = fast_open ? LK_OPEN : LK_WAIT;
        end
      end
      LK_WAIT: begin
        if (!sb_ok) begin
          next_lk = LK_DOWN;
        end else if (lk_cnt == CW'(LOCK_CYCLES - 1)) begin
          next_lk = LK_OPEN;
        end
      end
      LK_OPEN: begin
        if (!sb_ok) begin
          next_lk = LK_DOWN;
        end
      end
      default: next_lk = LK_DOWN;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux

  wire [7:0] rd_mux =
    is_time ? t_get(snap_on ? ucp : tm, avs_address) :
    (avs_address == IDX_SECA) ? alm.sec :
    (avs_address == IDX_MINA) ? alm.min :
    (avs_address == IDX_HOURA) ? alm.hour :
    (avs_address == IDX_DOMA) ? alm.dom :
    (avs_address == IDX_MONA) ? alm.mon :
    (avs_address == IDX_CRA) ? {uip, dv, rs} :
    (avs_address == IDX_CRB) ? control_reg_b :
    (avs_address == IDX_CRC) ? {irq_pending_flag, pf, af, uf, 4'h0} :
    (avs_address == IDX_CRD) ? {valid_time_flag, 7'h00} : 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack <= req & ~ack;
      if (req & ~ack) begin
        avs_readdata <= locked ? 32'h0 : {24'h0, rd_mux};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tm <= '0;
      ucp <= '0;
    end else begin
      tm <= next_tm;
      ucp <= next_ucp;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || init) begin
      alm <= '0;
      dv <= DV_RESET;
      rs <= 4'h0;
      control_reg_b <= CRB_RESET;
    end else begin
      if (wr & (avs_address == IDX_SECA)) alm.sec <= wd;
      if (wr & (avs_address == IDX_MINA)) alm.min <= wd;
      if (wr & (avs_address == IDX_HOURA)) alm.hour <= wd;
      if (wr & (avs_address == IDX_DOMA)) alm.dom <= wd;
      if (wr & (avs_address == IDX_MONA)) alm.mon <= wd;
      if (cra_wr) begin
        dv <= wd[CRA_DV_HI:CRA_DV_LO];
        rs <= wd[CRA_RS_HI:0];
      end
      if (crb_wr) control_reg_b <= wd;
    end
  end

  // flags: a new event beats a same-cycle clear
  always_ff @(posedge mclk) begin
    if (!reset_n || init) begin
      uf <= 1'b0;
      af <= 1'b0;
      pf <= 1'b0;
    end else begin
      uf <= upd | (uf & ~c_clr);
      af <= al_set | (af & ~c_clr);
      pf <= pfire | (pf & ~c_clr);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || init) begin
      div <= '0;
      uip <= 1'b0;
      upd_d <= 1'b0;
      pend_load <= 1'b0;
      wakeup_controller_alarm <= 1'b0;
    end else begin
      if (chain_rst) begin
        div <= '0;
      end else if (tk) begin
        div <= div_nx;
      end
      if (upd || chain_rst) begin
        uip <= 1'b0;
      end else if (uip_rise) begin
        uip <= 1'b1;
      end
      upd_d <= upd;
      wakeup_controller_alarm <= al_set;
      if (snap_drop) begin
        pend_load <= 1'b1;
      end else if (snap_take || load_now) begin
        pend_load <= 1'b0;
      end
    end
  end

  // standby presence with on/off hysteresis, then the lockout timer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sb_ok <= 1'b0;
      valid_time_flag <= 1'b0;
      lk <= LK_DOWN;
      lk_cnt <= '0;
    end else begin
      if (!sb_ok && standby_on_threshold) begin
        sb_ok <= 1'b1;
      end else if (sb_ok && !standby_off_threshold) begin
        sb_ok <= 1'b0;
      end
      valid_time_flag <= battery_detect_level;
      lk <= next_lk;
      lk_cnt <= (lk == LK_WAIT) ? lk_cnt + CW'(1) : '0;
    end
  end

endmodule : rtc_timekeeper
`default_nettype wire

// >>> inc/rtc_pkg.sv
/*
  Shared constants and types for the RTC timekeeping core.
  Assumes a 200 MHz mclk and a one-cycle osc_tick per 32.768 kHz period.
*/
package rtc_pkg;
  // register indexes (word address on the bus)
  localparam logic [3:0] IDX_SEC = 4'h0;
  localparam logic [3:0] IDX_SECA = 4'h1;
  localparam logic [3:0] IDX_MIN = 4'h2;
  localparam logic [3:0] IDX_MINA = 4'h3;
  localparam logic [3:0] IDX_HOUR = 4'h4;
  localparam logic [3:0] IDX_HOURA = 4'h5;
  localparam logic [3:0] IDX_DOW = 4'h6;
  localparam logic [3:0] IDX_DOM = 4'h7;
  localparam logic [3:0] IDX_MON = 4'h8;
  localparam logic [3:0] IDX_YEAR = 4'h9;
  localparam logic [3:0] IDX_CRA = 4'ha;
  localparam logic [3:0] IDX_CRB = 4'hb;
  localparam logic [3:0] IDX_CRC = 4'hc;
  localparam logic [3:0] IDX_CRD = 4'hd;
  localparam logic [3:0] IDX_DOMA = 4'he;
  localparam logic [3:0] IDX_MONA = 4'hf;
  // bit positions
  localparam int CRA_DV_HI = 6;
  localparam int CRA_DV_LO = 4;
  localparam int CRA_RS_HI = 3;
  localparam int CRB_SET = 7;
  localparam int CRB_PIE = 6;
  localparam int CRB_AIE = 5;
  localparam int CRB_UIE = 4;
  localparam int CRB_DM = 2;
  localparam int CRB_24H = 1;
  // divider control codes and the alarm don't-care top bits
  localparam logic [2:0] DV_STOP = 3'h0;
  localparam logic [2:0] DV_NORMAL = 3'h2;
  localparam logic [1:0] DV_RST_TOP = 2'h3;
  localparam logic [1:0] AL_DONT_CARE = 2'h3;
  // reset values
  localparam logic [2:0] DV_RESET = 3'h0;
  localparam logic [7:0] CRB_RESET = 8'h02;
  // timebase
  localparam int DIV_W = 15;
  localparam logic [14:0] UPD_POINT = 15'h4000;
  localparam int OSC_HZ = 32768;
  localparam int UIP_US = 244;
  localparam int UIP_TICKS = (UIP_US * OSC_HZ + 999999) / 1000000;
  localparam logic [14:0] UIP_START = UPD_POINT - 15'(UIP_TICKS);
  localparam logic [3:0] PER_SHIFT_R1 = 4'h7;
  localparam logic [3:0] PER_SHIFT_R2 = 4'h8;
  localparam int MCLK_HZ = 200000000;
  localparam int LOCK_MS = 62;
  localparam int LOCK_CYC = LOCK_MS * (MCLK_HZ / 1000);
  // calendar limits
  localparam logic [7:0] T_SEC_LAST = 8'h3b;
  localparam logic [7:0] T_MIN_LAST = 8'h3b;
  localparam logic [7:0] T_HR_LAST = 8'h17;
  localparam logic [7:0] T_DOW_LAST = 8'h07;
  localparam logic [7:0] T_MON_LAST = 8'h0c;
  localparam logic [7:0] T_YR_LAST = 8'h63;
  localparam logic [7:0] T_FIRST = 8'h01;
  localparam logic [7:0] HALF_DAY = 8'h0c;
  localparam logic [7:0] T_FEB = 8'h02;
  localparam logic [7:0] FEB_LEAP = 8'h1d;
  localparam logic [7:0] FEB_NORM = 8'h1c;
  localparam logic [7:0] SHORT_MON = 8'h1e;
  localparam logic [7:0] LONG_MON = 8'h1f;
  localparam logic [15:0] SHORT_MONTHS = 16'h0a50;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] dow;
    logic [7:0] dom;
    logic [7:0] mon;
    logic [7:0] year;
  } rtc_time_s;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] dom;
    logic [7:0] mon;
  } rtc_alarm_s;

  typedef enum logic [1:0] {
    LK_DOWN = 2'b00,
    LK_WAIT = 2'b01,
    LK_OPEN = 2'b10
  } rtc_lock_e;
endpackage : rtc_pkg

// >>> tb/rtc_timekeeper_properties.sv
/*
  Port-level assertions for rtc_timekeeper.
  Bound from the bench top file; sees only top-level ports.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeper_properties
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // supplies and status
  input wire logic standby_on_threshold,
  input wire logic standby_off_threshold,
  input wire logic irq,
  input wire logic wakeup_controller_alarm,
  input wire logic input_locked,
  input wire logic osc_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire logic req = avs_read | avs_write;
  wire logic crc_rd = avs_read && (avs_address == IDX_CRC) && !avs_waitrequest;
  //////////////////////////////////////////////////////////////////////////////
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("no wait state on first cycle");
  a_wait_ends: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  a_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_data_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_locked_zero: assert property (
    avs_read && !avs_waitrequest && input_locked && $past(input_locked) |-> avs_readdata == 32'h0)
    else $error("locked read returned data");
  a_lock_on_loss: assert property ($fell(standby_off_threshold) |-> ##[1:3] input_locked)
    else $error("no lockout after standby loss");
  a_lock_holds: assert property (input_locked && !standby_off_threshold |=> input_locked)
    else $error("lock released without standby");
  a_irq_cleared: assert property (crc_rd |=> !irq)
    else $error("irq kept after status read");
  a_irq_cause: assert property ($fell(irq) |-> $past(avs_write) || $past(crc_rd))
    else $error("irq dropped without cause");
  a_wake_pulse: assert property (wakeup_controller_alarm |=> !wakeup_controller_alarm)
    else $error("wake pulse longer than one cycle");
  a_osc_standby: assert property (standby_on_threshold [*3] |-> osc_active)
    else $error("oscillator off with standby present");
  //////////////////////////////////////////////////////////////////////////////
  c_irq: cover property ($rose(irq));
  c_wake: cover property (wakeup_controller_alarm);
  c_release: cover property ($fell(input_locked));
endmodule : rtc_timekeeper_properties
`default_nettype wire

// >>> tb/tb_rtc_timekeeper.sv
/*
  Self-checking bench for rtc_timekeeper: calendar roll, alarm, snapshot
  and supply lockout over Avalon-MM. osc_tick is held high so every mclk
  counts as one oscillator period; LOCK_CYCLES is cut to 20.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_timekeeper
  import rtc_pkg::*;
;
  // clock, reset and bus
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // timebase and supplies
  logic osc_tick = 1'b1;
  logic standby_on_threshold = 1'b1;
  logic standby_off_threshold = 1'b1;
  logic battery_detect_level = 1'b1;
  logic battery_min_level = 1'b1;
  logic bus_reset_in_n = 1'b1;
  // status
  logic irq;
  logic wakeup_controller_alarm;
  logic input_locked;
  logic osc_active;
  int mismatches = 0;
  int cmp_count = 0;
  int wakes = 0;
  int waited = 0;

  rtc_timekeeper #(.LOCK_CYCLES(20)) uut (
    .mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .osc_tick,
    .standby_on_threshold, .standby_off_threshold, .battery_detect_level,
    .battery_min_level, .bus_reset_in_n, .irq, .wakeup_controller_alarm,
    .input_locked, .osc_active
  );

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (wakeup_controller_alarm === 1'b1) wakes++;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkf(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkf

  // waitrequest and readdata read at the edge, before its updates land;
  // a hung slave is left to the watchdog
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h0, q);
    chk(q, {24'h0, e});
  endtask : rdc

  // extra cycles let the alarm flag land after the update flag
  task automatic wait_irq(input int lim);
    waited = 0;
    while (irq !== 1'b1 && waited < lim) begin
      @(posedge mclk);
      waited++;
    end
    chkf(irq, 1'b1);
    repeat (4) @(posedge mclk);
  endtask : wait_irq

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #450000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge mclk);
    chkf(input_locked, 1'b1);
    chkf(irq, 1'b0);
    reset_n <= 1'b1;
    // good battery after reset: the full lockout delay applies
    repeat (4) @(posedge mclk);
    chkf(input_locked, 1'b1);
    repeat (30) @(posedge mclk);
    chkf(input_locked, 1'b0);
    rdc(IDX_CRB, 8'h02);
    $display("reset test done");
    wr(IDX_SEC, 8'h59);
    wr(IDX_MIN, 8'h59);
    wr(IDX_HOUR, 8'h23);
    wr(IDX_DOW, 8'h03);
    wr(IDX_DOM, 8'h28);
    wr(IDX_MON, 8'h02);
    wr(IDX_YEAR, 8'h04);
    wr(IDX_SECA, 8'h00);
    wr(IDX_MINA, 8'hc0);
    wr(IDX_HOURA, 8'hc0);
    wr(IDX_DOMA, 8'hc0);
    wr(IDX_MONA, 8'hc0);
    wr(IDX_CRB, 8'h32);
    wr(IDX_CRA, 8'h20);
    wait_irq(17000);
    chkf(waited inside {[16370:16400]}, 1'b1);
    rdc(IDX_CRC, 8'hb0);
    chkf(irq, 1'b0);
    chk(32'(wakes), 32'h1);
    rdc(IDX_CRC, 8'h00);
    rdc(IDX_SEC, 8'h00);
    rdc(IDX_MIN, 8'h00);
    rdc(IDX_HOUR, 8'h00);
    rdc(IDX_DOW, 8'h04);
    rdc(IDX_DOM, 8'h29);
    rdc(IDX_MON, 8'h02);
    rdc(IDX_YEAR, 8'h04);
    $display("calendar test done");
    // a leaked copy write would make the alarm second match
    wr(IDX_CRB, 8'hb2);
    wr(IDX_SEC, 8'h59);
    wait_irq(33000);
    chkf(waited inside {[32600:32768]}, 1'b1);
    rdc(IDX_SEC, 8'h59);
    rdc(IDX_CRC, 8'h90);
    wr(IDX_CRB, 8'h32);
    rdc(IDX_SEC, 8'h59);
    rdc(IDX_MIN, 8'h00);
    $display("snapshot test done");
    standby_on_threshold <= 1'b0;
    standby_off_threshold <= 1'b0;
    repeat (4) @(posedge mclk);
    chkf(input_locked, 1'b1);
    chkf(osc_active, 1'b1);
    rdc(IDX_CRB, 8'h00);
    wr(IDX_CRB, 8'h00);
    standby_on_threshold <= 1'b1;
    standby_off_threshold <= 1'b1;
    repeat (4) @(posedge mclk);
    chkf(input_locked, 1'b0);
    rdc(IDX_CRB, 8'h32);
    wr(IDX_CRA, 8'h00);
    standby_on_threshold <= 1'b0;
    standby_off_threshold <= 1'b0;
    repeat (4) @(posedge mclk);
    chkf(osc_active, 1'b0);
    standby_on_threshold <= 1'b1;
    standby_off_threshold <= 1'b1;
    repeat (4) @(posedge mclk);
    chkf(input_locked, 1'b1);
    repeat (30) @(posedge mclk);
    chkf(input_locked, 1'b0);
    standby_on_threshold <= 1'b0;
    standby_off_threshold <= 1'b0;
    battery_detect_level <= 1'b0;
    repeat (4) @(posedge mclk);
    standby_on_threshold <= 1'b1;
    standby_off_threshold <= 1'b1;
    repeat (4) @(posedge mclk);
    chkf(input_locked, 1'b0);
    rdc(IDX_CRB, 8'h32);
    standby_on_threshold <= 1'b0;
    standby_off_threshold <= 1'b0;
    bus_reset_in_n <= 1'b0;
    repeat (4) @(posedge mclk);
    standby_on_threshold <= 1'b1;
    standby_off_threshold <= 1'b1;
    repeat (4) @(posedge mclk);
    chkf(input_locked, 1'b0);
    battery_detect_level <= 1'b1;
    bus_reset_in_n <= 1'b1;
    @(posedge mclk);
    rdc(IDX_CRB, 8'h02);
    rdc(IDX_SEC, 8'h00);
    $display("lockout test done");
    // binary 12-hour mode: 11:59:59 pm rolls to 12 am
    wr(IDX_CRB, 8'h14);
    wr(IDX_SEC, 8'h3b);
    wr(IDX_MIN, 8'h3b);
    wr(IDX_HOUR, 8'h8b);
    wr(IDX_CRA, 8'h23);
    wait_irq(17000);
    rdc(IDX_CRC, 8'hd0);
    rdc(IDX_HOUR, 8'h0c);
    rdc(IDX_SEC, 8'h00);
    $display("format test done");
    give_verdict();
  end
endmodule : tb_rtc_timekeeper

bind rtc_timekeeper rtc_timekeeper_properties u_props (
  .mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .standby_on_threshold, .standby_off_threshold, .irq,
  .wakeup_controller_alarm, .input_locked, .osc_active
);
`default_nettype wire
